// [include/fpo_params.svh]
// offsets, field positions, masks and reset values of the panel output registers
// assumes the indexed port holds register indices in the low byte
`ifndef FPO_PARAMS_SVH
`define FPO_PARAMS_SVH

`define FPO_IDX_VIDEO_IF 8'h28
`define FPO_IDX_DEFAULT_VIDEO 8'h2b
`define FPO_IDX_PANEL_FORMAT 8'h50
`define FPO_IDX_DISPLAY_TYPE 8'h51
`define FPO_IDX_PANEL_SIZE 8'h52
`define FPO_IDX_LG_OVERRIDE 8'h53
`define FPO_IDX_PANEL_MISC 8'h54
`define FPO_IDX_TEXT350_A 8'h55
`define FPO_IDX_TEXT350_B 8'h56
`define FPO_IDX_TEXT400 8'h57
`define FPO_IDX_GFX350 8'h58

`define FPO_MASK_VIDEO_IF 8'h0f
`define FPO_MASK_PANEL_FORMAT 8'hbf
`define FPO_MASK_PANEL_SIZE 8'h7b
`define FPO_MASK_LG_OVERRIDE 8'h03
`define FPO_MASK_PANEL_MISC 8'hcd
`define FPO_MASK_TEXT_COMP 8'h1f
`define FPO_MASK_GFX350 8'h7f

`define FPO_RST_DISPLAY_TYPE 8'h04
`define FPO_RST_ZERO 8'h00

`define FPO_VI_POLARITY 0
`define FPO_VI_BLANK_SEL 1
`define FPO_VI_SHUT_VIDEO 2
`define FPO_VI_SHUT_BLANK 3
`define FPO_PF_GATE 7
`define FPO_DT_DUAL_DRIVE 0
`define FPO_DT_COMPAT 6
`define FPO_DT_TEXT_POL 7
`define FPO_LG_OVR_EN 0
`define FPO_LG_OVR_VAL 1
`define FPO_PM_SKEW 0
`define FPO_PM_HPOL 6
`define FPO_PM_VPOL 7
`define FPO_TC_TYPE 4
`define FPO_GC_STRETCH 4
`define FPO_GC_DELETE 5

`endif

// [include/fpo_pkg.sv]
// types of the flat panel output block
// assumes fpo_params.svh supplies the numeric constants
package fpo_pkg;

   typedef enum logic [1:0] {FPO_LCD, FPO_CRT, FPO_PLASMA, FPO_DT_RSVD} fpo_disp_t;

   typedef struct packed {
      logic [7:0] video_if;
      logic [7:0] default_blank_video;
      logic [7:0] panel_format;
      logic [7:0] display_type;
      logic [7:0] panel_size;
      logic [7:0] line_graphics_override;
      logic [7:0] panel_misc_output;
      logic [7:0] text350_comp_a;
      logic [7:0] text350_comp_b;
      logic [7:0] text400_comp;
      logic [7:0] graphics350_comp;
   } fpo_cfg_t;

   typedef struct packed {
      logic display_window_signal;
      logic blank;
      logic screen_off;
      logic hsync;
      logic vsync;
      logic text_mode;
      logic double_scan;
      logic lines_350;
      logic char_height_bit3;
      logic attr_line_graphics_enable;
      logic line_end;
      logic row_end;
      logic weight_clk;
      logic [7:0] pixel;
   } fpo_vid_in_t;

   typedef struct packed {
      logic [1:0] frame_rate_gray_field;
      logic [1:0] panel_gray_field;
      logic [1:0] mono_color_select;
      logic dual_panel;
      logic dual_drive;
   } fpo_panel_t;

   typedef struct packed {
      fpo_cfg_t cfg;
      logic [7:0] index;
      logic [7:0] rdata;
      logic dot_prev;
      logic [2:0] dot_cnt;
      logic shift;
      logic group_strobe;
      logic blank_pin;
      logic wgt_pin;
      logic [7:0] pixel_stage;
      logic [7:0] pixel_out;
      logic hsync;
      logic vsync;
      logic line_gfx_en;
      fpo_panel_t panel;
      logic [4:0] ins_cnt;
      logic ins_active;
      logic [4:0] comp_cnt;
      logic replicate;
      logic skip;
   } fpo_state_t;

endpackage

// [rtl/fpo_flat_panel_output.sv]
// flat panel / crt pixel output shaping with its indexed configuration registers
// assumes all video inputs and dot clock levels are synchronous to sys_clk and
// that the dot clocks run at most at half the sys_clk rate
// Functional notes
// - video interface bit 1 picks display window (0) or blanking (1) for blank pin
// - polarity bit sets blank pin level for either selection
// - shut-off-video 0 forces default video in blank time, 1 when screen off
// - shut-off-blank 1 forces blank pin active while screen is switched off
// - forced pixel value is the 8-bit default video register
// - frame-rate gray field: none, 4 color levels, 16 mono levels, reserved
// - panel gray field: none, 4, 16, 256; 256 not with dual drive
// - shift clock is dot clock divided by 1, 2, 4 or 8
// - gate bit stops shift clock outside window, picks weighting clock pin source
// - display type lcd, crt, plasma; resets to crt; panel settings need flat panel
// - mono/color select: color 3-bit, color 4-bit, monochrome, reserved
// - compat enable turns vertical compensation on, off makes no adjustment
// - display type bit 7 inverts video only in flat panel text mode
// - override bit 0 lets bit 1 replace attribute line graphics enable
// - skew bit delays panel video by one clock
// - dot clock source select a, b, c; code 11 reserved
// - flat panel hsync polarity bit 6, vsync bit 7, 1 is negative
// - text comp type 0 inserts count plus one border lines per row, no gfx comp
// - text comp type 1 inserts nothing, graphics compensation may apply
// - 350-line text uses comp a when char height bit3 set else b; 200/400 uses third
// - replicate or skip a line after every interval of displayed lines
// - stretch enables replication, delete works only double scanned
`timescale 1ns/1ps
`include "fpo_params.svh"

module fpo_flat_panel_output (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic io_data_sel,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata_q,
   input wire logic dot_clock_src_a,
   input wire logic dot_clock_src_b,
   input wire logic dot_clock_src_c,
   input fpo_pkg::fpo_vid_in_t vid_in,
   output logic pixel_shift_clock,
   output logic pixel_group_strobe,
   output logic blank_pin,
   output logic weighting_clock_pin,
   output logic [7:0] pixel_out,
   output logic hsync_out,
   output logic vsync_out,
   output logic line_graphics_enable,
   output fpo_pkg::fpo_panel_t panel_mode,
   output logic insert_border_line,
   output logic replicate_line,
   output logic skip_line
);
   import fpo_pkg::*;

   fpo_state_t s_q;
   fpo_state_t s_d;

   logic [7:0] cfg_rd;
   logic flat;
   logic dot_lvl;
   logic [2:0] div_last;
   logic [7:0] text_comp;
   logic text_comp_on;
   logic gfx_comp_on;
   logic force_video;
   logic blank_active;
   logic [2:0] comp_inc;
   logic [4:0] comp_next;
   logic [7:0] pix_sel;

   always_comb begin
      unique case (s_q.index)
         `FPO_IDX_VIDEO_IF: cfg_rd = s_q.cfg.video_if;
         `FPO_IDX_DEFAULT_VIDEO: cfg_rd = s_q.cfg.default_blank_video;
         `FPO_IDX_PANEL_FORMAT: cfg_rd = s_q.cfg.panel_format;
         `FPO_IDX_DISPLAY_TYPE: cfg_rd = s_q.cfg.display_type;
         `FPO_IDX_PANEL_SIZE: cfg_rd = s_q.cfg.panel_size;
         `FPO_IDX_LG_OVERRIDE: cfg_rd = s_q.cfg.line_graphics_override;
         `FPO_IDX_PANEL_MISC: cfg_rd = s_q.cfg.panel_misc_output;
         `FPO_IDX_TEXT350_A: cfg_rd = s_q.cfg.text350_comp_a;
         `FPO_IDX_TEXT350_B: cfg_rd = s_q.cfg.text350_comp_b;
         `FPO_IDX_TEXT400: cfg_rd = s_q.cfg.text400_comp;
         `FPO_IDX_GFX350: cfg_rd = s_q.cfg.graphics350_comp;
         default: cfg_rd = 8'h00;
      endcase
   end

   always_comb begin
      s_d = s_q;
      // register port: address 0 holds the index, address 1 the indexed data
      if (io_wr && !io_data_sel) begin
         s_d.index = io_wdata;
      end
      if (io_wr && io_data_sel) begin
         unique case (s_q.index)
            `FPO_IDX_VIDEO_IF: s_d.cfg.video_if = io_wdata & `FPO_MASK_VIDEO_IF;
            `FPO_IDX_DEFAULT_VIDEO: s_d.cfg.default_blank_video = io_wdata;
            `FPO_IDX_PANEL_FORMAT: s_d.cfg.panel_format = io_wdata & `FPO_MASK_PANEL_FORMAT;
            `FPO_IDX_DISPLAY_TYPE: s_d.cfg.display_type = io_wdata;
            `FPO_IDX_PANEL_SIZE: s_d.cfg.panel_size = io_wdata & `FPO_MASK_PANEL_SIZE;
            `FPO_IDX_LG_OVERRIDE: begin
               s_d.cfg.line_graphics_override = io_wdata & `FPO_MASK_LG_OVERRIDE;
            end
            `FPO_IDX_PANEL_MISC: s_d.cfg.panel_misc_output = io_wdata & `FPO_MASK_PANEL_MISC;
            `FPO_IDX_TEXT350_A: s_d.cfg.text350_comp_a = io_wdata & `FPO_MASK_TEXT_COMP;
            `FPO_IDX_TEXT350_B: s_d.cfg.text350_comp_b = io_wdata & `FPO_MASK_TEXT_COMP;
            `FPO_IDX_TEXT400: s_d.cfg.text400_comp = io_wdata & `FPO_MASK_TEXT_COMP;
            `FPO_IDX_GFX350: s_d.cfg.graphics350_comp = io_wdata & `FPO_MASK_GFX350;
            default: s_d.cfg = s_q.cfg;
         endcase
      end
      if (io_rd) begin
         s_d.rdata = io_data_sel ? cfg_rd : s_q.index;
      end

      // panel settings only matter once a flat panel type is chosen
      flat = fpo_disp_t'(s_q.cfg.display_type[3:2]) == FPO_LCD ||
             fpo_disp_t'(s_q.cfg.display_type[3:2]) == FPO_PLASMA;

      // dot clock source; reserved code parks the divider
      unique case (s_q.cfg.panel_misc_output[3:2])
         2'b00: dot_lvl = dot_clock_src_a;
         2'b01: dot_lvl = dot_clock_src_b;
         2'b10: dot_lvl = dot_clock_src_c;
         default: dot_lvl = 1'b0;
      endcase
      s_d.dot_prev = dot_lvl;
      div_last = 3'((4'h1 << s_q.cfg.panel_format[5:4]) - 4'h1);
      s_d.group_strobe = 1'b0;
      if (dot_lvl && !s_q.dot_prev) begin
         // counting dot edges keeps each pixel group tied to one shift period
         s_d.dot_cnt = (s_q.dot_cnt >= div_last) ? 3'h0 : s_q.dot_cnt + 3'h1;
         s_d.group_strobe = (s_q.dot_cnt >= div_last);
      end
      if (div_last == 3'h0) begin
         s_d.shift = dot_lvl;
      end else begin
         s_d.shift = s_d.dot_cnt <= (div_last >> 1);
      end
      if (s_q.cfg.panel_format[`FPO_PF_GATE] && !vid_in.display_window_signal) begin
         s_d.shift = 1'b0;
      end
      s_d.wgt_pin = s_q.cfg.panel_format[`FPO_PF_GATE] ? vid_in.weight_clk :
                    vid_in.display_window_signal;

      // blank pin: source, screen-off forcing, then polarity
      blank_active = s_q.cfg.video_if[`FPO_VI_BLANK_SEL] ? vid_in.blank :
                     vid_in.display_window_signal;
      if (s_q.cfg.video_if[`FPO_VI_SHUT_BLANK] && vid_in.screen_off) begin
         blank_active = 1'b1;
      end
      // display window is true when active, so positive polarity passes it straight
      s_d.blank_pin = s_q.cfg.video_if[`FPO_VI_POLARITY] ? blank_active : !blank_active;

      force_video = s_q.cfg.video_if[`FPO_VI_SHUT_VIDEO] ? vid_in.screen_off :
                    vid_in.blank;
      pix_sel = vid_in.pixel;
      if (flat && vid_in.text_mode && s_q.cfg.display_type[`FPO_DT_TEXT_POL]) begin
         pix_sel = ~vid_in.pixel;
      end
      s_d.pixel_stage = force_video ? s_q.cfg.default_blank_video : pix_sel;
      s_d.pixel_out = (flat && s_q.cfg.panel_misc_output[`FPO_PM_SKEW]) ? s_q.pixel_stage :
                      s_d.pixel_stage;

      s_d.hsync = vid_in.hsync ^ (flat & s_q.cfg.panel_misc_output[`FPO_PM_HPOL]);
      s_d.vsync = vid_in.vsync ^ (flat & s_q.cfg.panel_misc_output[`FPO_PM_VPOL]);

      s_d.line_gfx_en = s_q.cfg.line_graphics_override[`FPO_LG_OVR_EN] ?
                        s_q.cfg.line_graphics_override[`FPO_LG_OVR_VAL] :
                        vid_in.attr_line_graphics_enable;

      // reserved codes and non-panel media report no gray generation
      s_d.panel.frame_rate_gray_field = (flat && s_q.cfg.panel_format[1:0] != 2'b11) ?
                                        s_q.cfg.panel_format[1:0] : 2'b00;
      s_d.panel.panel_gray_field = s_q.cfg.panel_format[3:2];
      if (!flat || (s_q.cfg.panel_format[3:2] == 2'b11 &&
                    s_q.cfg.display_type[`FPO_DT_DUAL_DRIVE])) begin
         s_d.panel.panel_gray_field = 2'b00;
      end
      s_d.panel.mono_color_select = (flat && s_q.cfg.display_type[5:4] != 2'b11) ?
                                    s_q.cfg.display_type[5:4] : 2'b00;
      // drive type is trusted as software sets it, only for dual panels
      s_d.panel.dual_panel = flat & s_q.cfg.display_type[1];
      s_d.panel.dual_drive = flat & s_q.cfg.display_type[1] &
                             s_q.cfg.display_type[`FPO_DT_DUAL_DRIVE];

      // vertical compensation
      text_comp = vid_in.lines_350 ?
                  (vid_in.char_height_bit3 ? s_q.cfg.text350_comp_a :
                   s_q.cfg.text350_comp_b) : s_q.cfg.text400_comp;
      text_comp_on = flat && s_q.cfg.display_type[`FPO_DT_COMPAT] && vid_in.text_mode &&
                     !text_comp[`FPO_TC_TYPE];
      gfx_comp_on = flat && s_q.cfg.display_type[`FPO_DT_COMPAT] && vid_in.lines_350 &&
                    (!vid_in.text_mode || text_comp[`FPO_TC_TYPE]);
      if (!text_comp_on) begin
         s_d.ins_active = 1'b0;
         s_d.ins_cnt = 5'h0;
      end else if (vid_in.row_end) begin
         s_d.ins_active = 1'b1;
         s_d.ins_cnt = {1'b0, text_comp[3:0]} + 5'h1;
      end else if (vid_in.line_end && s_q.ins_active) begin
         s_d.ins_cnt = s_q.ins_cnt - 5'h1;
         s_d.ins_active = s_q.ins_cnt != 5'h1;
      end

      s_d.replicate = 1'b0;
      s_d.skip = 1'b0;
      comp_inc = vid_in.double_scan ? 3'h2 : 3'h1;
      comp_next = s_q.comp_cnt + {2'b00, comp_inc};
      if (!gfx_comp_on) begin
         s_d.comp_cnt = 5'h0;
      end else if (vid_in.line_end) begin
         if (comp_next >= {1'b0, s_q.cfg.graphics350_comp[3:0]}) begin
            s_d.comp_cnt = 5'h0;
            s_d.replicate = s_q.cfg.graphics350_comp[`FPO_GC_STRETCH];
            // deletion only drops the second of a doubled pair, so nothing is lost
            s_d.skip = !s_q.cfg.graphics350_comp[`FPO_GC_STRETCH] &&
                       s_q.cfg.graphics350_comp[`FPO_GC_DELETE] &&
                       vid_in.double_scan;
         end else begin
            s_d.comp_cnt = comp_next;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.cfg.display_type <= `FPO_RST_DISPLAY_TYPE;
         s_q.blank_pin <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign io_rdata_q = s_q.rdata;
   assign pixel_shift_clock = s_q.shift;
   assign pixel_group_strobe = s_q.group_strobe;
   assign blank_pin = s_q.blank_pin;
   assign weighting_clock_pin = s_q.wgt_pin;
   assign pixel_out = s_q.pixel_out;
   assign hsync_out = s_q.hsync;
   assign vsync_out = s_q.vsync;
   assign line_graphics_enable = s_q.line_gfx_en;
   assign panel_mode = s_q.panel;
   assign insert_border_line = s_q.ins_active;
   assign replicate_line = s_q.replicate;
   assign skip_line = s_q.skip;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   chk_blank_sel_src: assert property (
      s_q.cfg.video_if[3:0] == 4'b0011 |=> blank_pin == $past(vid_in.blank))
      else $error("blank pin does not follow blanking");
   chk_blank_neg_pol: assert property (
      s_q.cfg.video_if[3:0] == 4'b0000 |=> blank_pin == !$past(vid_in.display_window_signal))
      else $error("negative polarity display window wrong");
   chk_force_default: assert property (
      (!s_q.cfg.video_if[2] && vid_in.blank && !s_q.cfg.panel_misc_output[0])
      |=> pixel_out == $past(s_q.cfg.default_blank_video))
      else $error("default video not forced in blank time");
   chk_screen_off_blank: assert property (
      (s_q.cfg.video_if[3] && vid_in.screen_off) |=> blank_pin == $past(s_q.cfg.video_if[0]))
      else $error("blank pin not forced active when screen off");
   chk_skew_delay: assert property (
      (flat && s_q.cfg.panel_misc_output[0] && $stable(s_q.cfg))
      |=> pixel_out == $past(s_q.pixel_stage))
      else $error("skewed video not delayed one clock");
   chk_gate_low: assert property (
      (s_q.cfg.panel_format[7] && !vid_in.display_window_signal) |=> !pixel_shift_clock)
      else $error("gated shift clock not low outside window");
   chk_hsync_neg: assert property (
      (flat && s_q.cfg.panel_misc_output[6]) |=> hsync_out == !$past(vid_in.hsync))
      else $error("flat panel hsync polarity wrong");
   chk_lg_override: assert property (
      s_q.cfg.line_graphics_override[0]
      |=> line_graphics_enable == $past(s_q.cfg.line_graphics_override[1]))
      else $error("line graphics override ignored");
   chk_no_256_dual: assert property (
      s_q.cfg.display_type[0] |=> panel_mode.panel_gray_field != 2'b11)
      else $error("256 levels reported on dual drive");
   chk_insert_count: assert property (
      (text_comp_on && vid_in.row_end) |=> s_q.ins_cnt == {1'b0, $past(text_comp[3:0])} + 5'h1)
      else $error("inserted line count wrong");
   chk_skip_double: assert property (
      skip_line |-> $past(vid_in.double_scan) && !replicate_line)
      else $error("line skipped without double scan");
   chk_compat_off: assert property (
      !s_q.cfg.display_type[6] |=> !replicate_line && !skip_line && !insert_border_line)
      else $error("adjustment while compatibility off");
   chk_reset_crt: assert property (
      $rose(reset_n) |-> s_q.cfg.display_type[3:2] == 2'b01)
      else $error("display type not crt after reset");

   cov_insert_lines: cover property (insert_border_line ##1 !insert_border_line);
   cov_replicate: cover property (replicate_line);
   cov_div8_group: cover property (s_q.cfg.panel_format[5:4] == 2'b11 && pixel_group_strobe);
endmodule

// [verif/fpo_panel_model.sv]
// panel side model: counts shift clock rises and pixel group strobes
// assumes the bench clears the counts before each measurement window
`timescale 1ns/1ps
module fpo_panel_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic pixel_shift_clock,
   input wire logic pixel_group_strobe,
   output int shift_rises,
   output int strobes
);
   logic shift_prev = 1'b0;
   // edges are taken on sys_clk, so a shift clock faster than half that rate is miscounted
   always @(posedge sys_clk) begin
      shift_prev <= pixel_shift_clock;
      if (!reset_n || clear) begin
         shift_rises <= 0;
         strobes <= 0;
      end else begin
         if (pixel_shift_clock === 1'b1 && shift_prev === 1'b0) shift_rises <= shift_rises + 1;
         if (pixel_group_strobe === 1'b1) strobes <= strobes + 1;
      end
   end
endmodule

// [verif/tb.sv]
// self-checking bench of the flat panel output block against a register/video model
// assumes dot clocks made here at 1/2, 1/4 and 1/8 of sys_clk
`timescale 1ns/1ps
`include "fpo_params.svh"
module tb;
   import fpo_pkg::*;
   logic sys_clk = 0, reset_n = 0, io_wr = 0, io_rd = 0, io_data_sel = 0, clear = 0;
   logic [7:0] io_wdata = 8'h00, io_rdata_q, pixel_out;
   logic [2:0] dot_cnt = 3'h0;
   fpo_vid_in_t vid = '0;
   logic shift, strobe, blank_pin, wgt, hs, vs, lge, ins, rep, skp;
   fpo_panel_t pm;
   int n_mismatch = 0, n_checks = 0, cycles = 0, rises, strobes, reps, skips, dots;
   integer seed = 32'h286177c7;
   logic [31:0] r;
   logic [7:0] dt, px, shadow [int];
   logic [7:0] q [$];
   logic [7:0] idxs [11] = '{`FPO_IDX_VIDEO_IF, `FPO_IDX_DEFAULT_VIDEO, `FPO_IDX_PANEL_FORMAT,
      `FPO_IDX_DISPLAY_TYPE, `FPO_IDX_PANEL_SIZE, `FPO_IDX_LG_OVERRIDE, `FPO_IDX_PANEL_MISC,
      `FPO_IDX_TEXT350_A, `FPO_IDX_TEXT350_B, `FPO_IDX_TEXT400, `FPO_IDX_GFX350};

   fpo_flat_panel_output i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .io_wr(io_wr),
      .io_rd(io_rd), .io_data_sel(io_data_sel), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
      .dot_clock_src_a(dot_cnt[0]), .dot_clock_src_b(dot_cnt[1]), .dot_clock_src_c(dot_cnt[2]),
      .vid_in(vid), .pixel_shift_clock(shift), .pixel_group_strobe(strobe),
      .blank_pin(blank_pin), .weighting_clock_pin(wgt), .pixel_out(pixel_out),
      .hsync_out(hs), .vsync_out(vs), .line_graphics_enable(lge), .panel_mode(pm),
      .insert_border_line(ins), .replicate_line(rep), .skip_line(skp));
   fpo_panel_model i_panel (.sys_clk(sys_clk), .reset_n(reset_n), .clear(clear),
      .pixel_shift_clock(shift), .pixel_group_strobe(strobe), .shift_rises(rises),
      .strobes(strobes));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      dot_cnt <= dot_cnt + 3'h1;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (rep === 1'b1) reps++;
      if (skp === 1'b1) skips++;
      if (cycles == 30000) begin
         n_mismatch++;
         test_done;
      end
   end

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_in(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // unlisted indices keep nothing, so their mask is zero
   function automatic logic [7:0] msk(input logic [7:0] idx);
      case (idx)
         `FPO_IDX_VIDEO_IF: return `FPO_MASK_VIDEO_IF;
         `FPO_IDX_DEFAULT_VIDEO, `FPO_IDX_DISPLAY_TYPE: return 8'hff;
         `FPO_IDX_PANEL_FORMAT: return `FPO_MASK_PANEL_FORMAT;
         `FPO_IDX_PANEL_SIZE: return `FPO_MASK_PANEL_SIZE;
         `FPO_IDX_LG_OVERRIDE: return `FPO_MASK_LG_OVERRIDE;
         `FPO_IDX_PANEL_MISC: return `FPO_MASK_PANEL_MISC;
         `FPO_IDX_TEXT350_A, `FPO_IDX_TEXT350_B, `FPO_IDX_TEXT400: return `FPO_MASK_TEXT_COMP;
         `FPO_IDX_GFX350: return `FPO_MASK_GFX350;
         default: return 8'h00;
      endcase
   endfunction
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      @(negedge sys_clk) {io_wr, io_data_sel, io_wdata} = {2'b10, idx};
      @(negedge sys_clk) {io_data_sel, io_wdata} = {1'b1, val};
      @(negedge sys_clk) io_wr = 1'b0;
      if (msk(idx) != 8'h00) shadow[idx] = val & msk(idx);
   endtask
   task automatic rd(input logic [7:0] idx);
      @(negedge sys_clk) {io_wr, io_data_sel, io_wdata} = {2'b10, idx};
      @(negedge sys_clk) {io_wr, io_rd, io_data_sel} = 3'b011;
      @(negedge sys_clk) io_rd = 1'b0;
      @(negedge sys_clk) chk(io_rdata_q, shadow.exists(idx) ? shadow[idx] : 8'h00);
   endtask
   task automatic vstep;
      logic [7:0] vi, pmo, pf, lo;
      logic flat, act;
      vi = shadow[`FPO_IDX_VIDEO_IF];
      pmo = shadow[`FPO_IDX_PANEL_MISC];
      pf = shadow[`FPO_IDX_PANEL_FORMAT];
      lo = shadow[`FPO_IDX_LG_OVERRIDE];
      flat = !shadow[`FPO_IDX_DISPLAY_TYPE][2];
      r = $random(seed);
      // line and row pulses stay low here, so the random word clears them in one write
      @(negedge sys_clk) vid = r[20:0] & 21'h1ff9ff;
      @(negedge sys_clk);
      act = vi[1] ? vid.blank : vid.display_window_signal;
      if (vi[3] && vid.screen_off) act = 1'b1;
      if (vi[1] || !vi[3]) chk(blank_pin, vi[0] ? act : !act);
      px = vid.pixel;
      if (flat && vid.text_mode && shadow[`FPO_IDX_DISPLAY_TYPE][7]) px = ~px;
      if (vi[2] ? vid.screen_off : vid.blank) px = shadow[`FPO_IDX_DEFAULT_VIDEO];
      if (!(flat && pmo[0])) chk(pixel_out, px);
      chk(hs, vid.hsync ^ (flat & pmo[6]));
      chk(vs, vid.vsync ^ (flat & pmo[7]));
      chk(wgt, pf[7] ? vid.weight_clk : vid.display_window_signal);
      chk(lge, lo[0] ? lo[1] : vid.attr_line_graphics_enable);
   endtask
   task automatic count(input int n);
      @(negedge sys_clk) clear = 1'b1;
      @(negedge sys_clk) clear = 1'b0;
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic run_ins(input int exp);
      int n;
      n = 0;
      @(negedge sys_clk) vid.row_end = 1'b1;
      @(negedge sys_clk) vid.row_end = 1'b0;
      repeat (2) @(negedge sys_clk);
      while (ins === 1'b1 && n < 40) begin
         vid.line_end = 1'b1;
         @(negedge sys_clk) vid.line_end = 1'b0;
         n++;
         repeat (2) @(negedge sys_clk);
      end
      chk(n, exp);
   endtask
   task automatic lines(input int n);
      reps = 0;
      skips = 0;
      repeat (n) begin
         @(negedge sys_clk) vid.line_end = 1'b1;
         @(negedge sys_clk) vid.line_end = 1'b0;
         repeat (2) @(negedge sys_clk);
      end
   endtask

   initial begin
      foreach (idxs[i]) shadow[idxs[i]] = 8'h00;
      shadow[`FPO_IDX_DISPLAY_TYPE] = `FPO_RST_DISPLAY_TYPE;
      repeat (16) @(negedge sys_clk);
      reset_n = 1'b1;
      foreach (idxs[i]) rd(idxs[i]);
      rd(8'h30);
      foreach (idxs[i]) begin
         wr(idxs[i], 8'($random(seed)));
         rd(idxs[i]);
      end
      repeat (30) begin
         r = $random(seed);
         wr(`FPO_IDX_VIDEO_IF, r[7:0]);
         wr(`FPO_IDX_PANEL_FORMAT, r[15:8]);
         wr(`FPO_IDX_LG_OVERRIDE, r[23:16]);
         wr(`FPO_IDX_PANEL_MISC, r[31:24]);
         r = $random(seed);
         dt = r[7:0];
         dt[0] = dt[0] & dt[1];
         wr(`FPO_IDX_DISPLAY_TYPE, dt);
         wr(`FPO_IDX_DEFAULT_VIDEO, r[15:8]);
         repeat (8) vstep;
         px = shadow[`FPO_IDX_PANEL_FORMAT];
         if (!(px[3:2] == 2'b11 && dt[0])) chk(pm, dt[2] ? 8'h00 : {(px[1:0] == 2'b11) ?
            2'b00 : px[1:0], px[3:2], (dt[5:4] == 2'b11) ? 2'b00 : dt[5:4], dt[1:0]});
      end
      wr(`FPO_IDX_DISPLAY_TYPE, 8'h00);
      wr(`FPO_IDX_PANEL_MISC, 8'h01);
      wr(`FPO_IDX_VIDEO_IF, 8'h00);
      vid = '0;
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk);
         if (i >= 2) chk(pixel_out, q.pop_front());
         vid.pixel = 8'($random(seed));
         q.push_back(vid.pixel);
      end
      for (int s = 0; s < 4; s++) begin
         for (int cd = 0; cd < 4; cd++) begin
            wr(`FPO_IDX_PANEL_MISC, 8'(s << 2));
            wr(`FPO_IDX_PANEL_FORMAT, 8'(cd << 4));
            count(256);
            dots = (s == 3) ? 0 : (128 >> s) >> cd;
            chk_in(strobes, dots - 1, dots + 1);
            chk_in(rises, dots - 1, dots + 1);
         end
      end
      wr(`FPO_IDX_PANEL_MISC, 8'h00);
      wr(`FPO_IDX_PANEL_FORMAT, 8'h90);
      count(64);
      chk_in(rises, 0, 0);
      vid.display_window_signal = 1'b1;
      count(64);
      chk_in(rises, 15, 17);
      wr(`FPO_IDX_TEXT350_A, 8'h02);
      wr(`FPO_IDX_TEXT350_B, 8'h00);
      wr(`FPO_IDX_TEXT400, 8'h05);
      wr(`FPO_IDX_GFX350, 8'h13);
      wr(`FPO_IDX_DISPLAY_TYPE, 8'h40);
      vid = '0;
      vid.text_mode = 1'b1;
      reps = 0;
      {vid.lines_350, vid.char_height_bit3} = 2'b11;
      run_ins(3);
      {vid.lines_350, vid.char_height_bit3} = 2'b10;
      run_ins(1);
      {vid.lines_350, vid.char_height_bit3} = 2'b01;
      run_ins(6);
      chk(reps, 0);
      {vid.lines_350, vid.char_height_bit3} = 2'b11;
      wr(`FPO_IDX_DISPLAY_TYPE, 8'h00);
      run_ins(0);
      wr(`FPO_IDX_DISPLAY_TYPE, 8'h40);
      wr(`FPO_IDX_TEXT350_A, 8'h12);
      run_ins(0);
      lines(6);
      chk_in(reps, 1, 2);
      vid.text_mode = 1'b0;
      lines(12);
      chk_in(reps, 3, 4);
      wr(`FPO_IDX_GFX350, 8'h23);
      lines(12);
      chk_in(skips, 0, 0);
      vid.double_scan = 1'b1;
      lines(12);
      chk_in(skips, 6, 8);
      chk_in(reps, 0, 0);
      test_done;
   end
endmodule
